// File: inc/tx_test_loop_map.vh
// Register offsets, field positions and reset values of the transmit test and loop bank
`ifndef TX_TEST_LOOP_MAP_VH
`define TX_TEST_LOOP_MAP_VH
`define ADDR_PATTERN_ERROR_FLOAT 8'hb5
`define ADDR_OUTPUT_SWING 8'hb8
`define ADDR_DETECTOR_ACQ_GAIN 8'hcd
`define ADDR_ACQ_LOOP_FILTER 8'he2
`define RST_OUTPUT_SWING 8'hf5
`define RST_DETECTOR_ACQ_GAIN 8'h8d
`define RST_ACQ_LOOP_FILTER 8'h1e
`define SWING_FIXED_TOP 2'h3
`define SWING_SEL_MSB 2
`define GAIN_FIELD_LSB 5
`define FILTER_OVERRIDE_BIT 7
`define FILTER_VALUE_MSB 6
`define MANT_MSB 7
`define MANT_LSB 4
`define EXP_MSB 3
`define EXP_LSB 0
`endif

// File: logic/tx_test_and_loop_ctl_regs.v
// APB register bank for transmit error report, swing select and loop filter override
`timescale 1ns/1ps
`include "tx_test_loop_map.vh"

module tx_test_and_loop_ctl_regs (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  input wire [39:0] i_tx_pattern_error_counter,
  input wire i_tx_pattern_error_valid,
  input wire [6:0] i_tx_acq_filter_internal,
  input wire i_tx_lock_lost,
  output reg [2:0] o_tx_out_swing_select,
  output reg [1:0] o_hs_power_field,
  output reg [2:0] o_tx_detector_acq_gain,
  output reg [4:0] o_tx_detector_trim,
  output reg [6:0] o_tx_acq_filter_value,
  output reg o_tx_acq_filter_override_en
);

  // Reset images as vectors,
  // so single fields can be sliced out
  localparam [7:0] SWING_RST = `RST_OUTPUT_SWING;
  localparam [7:0] GAIN_RST = `RST_DETECTOR_ACQ_GAIN;
  localparam [7:0] FILTER_RST = `RST_ACQ_LOOP_FILTER;
  localparam [2:0] SWING_MID = SWING_RST[5:3];

  // Register select codes from the address decoder
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_FLOAT = 3'h1;
  localparam [2:0] SEL_SWING = 3'h2;
  localparam [2:0] SEL_GAIN = 3'h3;
  localparam [2:0] SEL_FILTER = 3'h4;

  // Bus phase tracker states, one-hot
  localparam [2:0] PH_IDLE = 3'b001;
  localparam [2:0] PH_SETUP = 3'b010;
  localparam [2:0] PH_ACCESS = 3'b100;

  // Register images
  // Float has no writer on the bus side
  reg [7:0] tx_pattern_error_float;
  reg [7:0] tx_output_swing;
  reg [7:0] tx_detector_acq_gain;
  reg [7:0] tx_acq_loop_filter;

  // Bus phase, decode and strobes
  reg [2:0] phase;
  reg [2:0] next_phase;
  wire [2:0] sel;
  wire hit;
  wire unmapped;
  wire setup;
  wire access;
  wire wr_req;
  wire wr_en;
  wire wr_swing;
  wire wr_gain;
  wire wr_filter;
  wire rd_capture;
  reg [7:0] read_mux;

  // Next register images and the filter value the loop is fed
  wire [7:0] next_swing;
  wire [7:0] next_gain;
  wire [7:0] next_filter;
  reg [6:0] filter_in_use;
  wire [7:0] filter_readback;

  // Float encoder chain, one stage per hex digit
  wire [9:0] digit_nz;
  wire [7:0] float_chain [0:10];
  wire [7:0] next_float;
  genvar g;

  // Map a byte address onto one register
  // SEL_NONE means unmapped
  function [2:0] decode;
    input [31:0] addr;
    begin
      case (addr)
        {22'h0, `ADDR_PATTERN_ERROR_FLOAT, 2'h0}: decode = SEL_FLOAT;
        {22'h0, `ADDR_OUTPUT_SWING, 2'h0}: decode = SEL_SWING;
        {22'h0, `ADDR_DETECTOR_ACQ_GAIN, 2'h0}: decode = SEL_GAIN;
        {22'h0, `ADDR_ACQ_LOOP_FILTER, 2'h0}: decode = SEL_FILTER;
        default: decode = SEL_NONE;
      endcase
    end
  endfunction

  // Leading nonzero digit wins; lower digits are dropped, so the
  // report undercounts by less than one step of its exponent
  assign float_chain[0] = 8'h00;
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_digit
      localparam integer EXPO_I = g + 1;
      localparam [3:0] EXPO = EXPO_I[3:0];
      assign digit_nz[g] = |i_tx_pattern_error_counter[g*4 +: 4];
      assign float_chain[g + 1] = digit_nz[g] ?
                                  {i_tx_pattern_error_counter[g*4 +: 4], EXPO} :
                                  float_chain[g];
    end
  endgenerate
  assign next_float = float_chain[10];

  // Phase tracker; an access counts only right after a setup cycle,
  // so a master that holds penable cannot write twice
  always @* begin
    case (phase)
      PH_IDLE: begin
        if (setup) begin
          next_phase = PH_SETUP;
        end else begin
          next_phase = PH_IDLE;
        end
      end
      PH_SETUP: begin
        if (i_psel & i_penable) begin
          next_phase = PH_ACCESS;
        end else if (setup) begin
          next_phase = PH_SETUP;
        end else begin
          next_phase = PH_IDLE;
        end
      end
      PH_ACCESS: begin
        if (setup) begin
          next_phase = PH_SETUP;
        end else begin
          next_phase = PH_IDLE;
        end
      end
      default: begin
        next_phase = PH_IDLE;
      end
    endcase
  end

  // Phase register
  // Access lasts one cycle since pready is always high
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // Zero-wait slave; read data is captured in the setup cycle so it
  // already stands at the access edge that samples pready
  assign sel = decode(i_paddr);
  assign hit = (sel != SEL_NONE);
  assign unmapped = ~hit;
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable & (phase == PH_SETUP);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & unmapped;
  assign wr_req = access & i_pwrite & i_pstrb[0];
  assign wr_en = wr_req & hit;
  assign wr_swing = wr_en & (sel == SEL_SWING);
  assign wr_gain = wr_en & (sel == SEL_GAIN);
  assign wr_filter = wr_en & (sel == SEL_FILTER);
  assign rd_capture = setup & ~i_pwrite & hit;

  // Write images; swing middle bits keep their fixed pattern,
  // the other words are taken whole
  assign next_swing = {i_pwdata[7:6], SWING_MID, i_pwdata[`SWING_SEL_MSB:0]};
  assign next_gain = i_pwdata[7:0];
  assign next_filter = i_pwdata[7:0];

  // Override picks the written filter value, else the internal one;
  // software owns the timing around lock loss
  always @* begin
    if (tx_acq_loop_filter[`FILTER_OVERRIDE_BIT]) begin
      filter_in_use = tx_acq_loop_filter[`FILTER_VALUE_MSB:0];
    end else begin
      filter_in_use = i_tx_acq_filter_internal;
    end
  end

  // Float report follows each checker result
  // Reset value is a don't-care; bus writes to it are dropped
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_pattern_error_float <= 8'h00;
    end else if (i_tx_pattern_error_valid) begin
      tx_pattern_error_float <= next_float;
    end
  end

  // Swing word
  // Top bits kept as written; software must write 11
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_output_swing <= SWING_RST;
    end else if (wr_swing) begin
      tx_output_swing <= next_swing;
    end
  end

  // Gain word
  // Reserved low bits stored as written
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_detector_acq_gain <= GAIN_RST;
    end else if (wr_gain) begin
      tx_detector_acq_gain <= next_gain;
    end
  end

  // Filter word
  // Override bit and written value
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_acq_loop_filter <= FILTER_RST;
    end else if (wr_filter) begin
      tx_acq_loop_filter <= next_filter;
    end
  end

  // Filter reads the value the loop really uses, not the last write,
  // so a readback may differ from what was written
  assign filter_readback = {tx_acq_loop_filter[`FILTER_OVERRIDE_BIT],
                            o_tx_acq_filter_value};

  // Read multiplexer
  always @* begin
    case (sel)
      SEL_FLOAT: begin
        read_mux = tx_pattern_error_float;
      end
      SEL_SWING: begin
        read_mux = tx_output_swing;
      end
      SEL_GAIN: begin
        read_mux = tx_detector_acq_gain;
      end
      SEL_FILTER: begin
        read_mux = filter_readback;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // Read data registered in the setup cycle
  // Upper bytes are always zero
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata[31:8] <= 24'h000000;
      o_prdata[7:0] <= 8'h00;
    end else if (rd_capture) begin
      o_prdata[31:8] <= 24'h000000;
      o_prdata[7:0] <= read_mux;
    end
  end

  // Swing select to the output driver
  // Registered to keep the analog control glitch free
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_out_swing_select <= SWING_RST[2:0];
    end else begin
      o_tx_out_swing_select <= tx_output_swing[`SWING_SEL_MSB:0];
    end
  end

  // Power field follows the top swing bits
  // Passed through unchecked; the value is software's duty
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hs_power_field <= SWING_RST[7:6];
    end else begin
      o_hs_power_field <= tx_output_swing[7:6];
    end
  end

  // Detector gain during acquisition
  // Reset image until software writes it
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_detector_acq_gain <= GAIN_RST[7:5];
    end else begin
      o_tx_detector_acq_gain <= tx_detector_acq_gain[7:`GAIN_FIELD_LSB];
    end
  end

  // Detector trim from the reserved low bits
  // Passed through so a wrong write is visible
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_detector_trim <= GAIN_RST[4:0];
    end else begin
      o_tx_detector_trim <= tx_detector_acq_gain[4:0];
    end
  end

  // Override flag to the loop
  // Cleared at reset, so the internal value drives the loop from the first clock after reset; in reset the value output is zero
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_acq_filter_override_en <= FILTER_RST[7];
    end else begin
      o_tx_acq_filter_override_en <= tx_acq_loop_filter[`FILTER_OVERRIDE_BIT];
    end
  end

  // Filter value the loop uses
  // One cycle behind the register, like the other controls
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_acq_filter_value <= 7'h00;
    end else begin
      o_tx_acq_filter_value <= filter_in_use;
    end
  end

endmodule // tx_test_and_loop_ctl_regs

// File: test/tx_test_and_loop_ctl_regs_props.sv
// Checker for the bank's APB answers and control outputs
`timescale 1ns/1ps
module tx_test_and_loop_ctl_regs_props (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  input wire o_pready,
  input wire o_pslverr,
  input wire [31:0] o_prdata,
  input wire [2:0] o_tx_out_swing_select,
  input wire [2:0] o_tx_detector_acq_gain,
  input wire [6:0] o_tx_acq_filter_value,
  input wire o_tx_acq_filter_override_en
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Access phase and decode of the four mapped words
  wire acc = i_psel & i_penable;
  wire hit = i_paddr == 32'h2d4 || i_paddr == 32'h2e0 || i_paddr == 32'h334 || i_paddr == 32'h388;
  sequence wr(a);
    acc && i_pwrite && i_pstrb[0] && i_paddr == a;
  endsequence
  a_ready_now: assert property (acc |-> o_pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> o_pslverr) else $error("no pslverr");
  a_rdata_byte: assert property (o_prdata[31:8] == 24'h0) else $error("prdata high bits");
  a_rdata_hold: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
    else $error("prdata moved");
  a_read_mid: assert property (i_psel && !i_penable && !i_pwrite && i_paddr == 32'h2e0 |=> o_prdata[5:3] == 3'h6)
    else $error("swing middle bits");
  a_swing_write: assert property (wr(32'h2e0) |-> ##2 o_tx_out_swing_select == $past(i_pwdata[2:0], 2))
    else $error("swing select");
  a_gain_write: assert property (wr(32'h334) |-> ##2 o_tx_detector_acq_gain == $past(i_pwdata[7:5], 2))
    else $error("gain field");
  a_filter_ovr: assert property (wr(32'h388) |-> ##2 o_tx_acq_filter_override_en == $past(i_pwdata[7], 2))
    else $error("override bit");
  a_filter_val: assert property (wr(32'h388) && i_pwdata[7] |-> ##2 o_tx_acq_filter_value == $past(i_pwdata[6:0], 2))
    else $error("filter value");
endmodule // tx_test_and_loop_ctl_regs_props
bind tx_test_and_loop_ctl_regs tx_test_and_loop_ctl_regs_props tx_test_and_loop_ctl_regs_props_i (
  .i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready,
  .o_pslverr, .o_prdata, .o_tx_out_swing_select, .o_tx_detector_acq_gain, .o_tx_acq_filter_value,
  .o_tx_acq_filter_override_en);

// File: test/tx_test_and_loop_ctl_regs_test.sv
// Self-checking bench for the transmit test and loop bank
`timescale 1ns/1ps
module tx_test_and_loop_ctl_regs_test;
  reg i_core_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, vld = 0, lol = 0, err;
  reg [31:0] i_paddr = 0, i_pwdata = 0, rd;
  reg [39:0] cnt = 0;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, ovr;
  wire [2:0] sw, gn;
  integer miscompares = 0, n_compared = 0, k;
  always #4 i_core_clk = ~i_core_clk;
  tx_test_and_loop_ctl_regs tx_test_and_loop_ctl_regs_i (.i_core_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb(4'h1), .o_pready, .o_pslverr, .o_prdata,
    .i_tx_pattern_error_counter(cnt), .i_tx_pattern_error_valid(vld),
    .i_tx_acq_filter_internal(7'h1e), .i_tx_lock_lost(lol), .o_tx_out_swing_select(sw),
    .o_hs_power_field(), .o_tx_detector_acq_gain(gn), .o_tx_detector_trim(),
    .o_tx_acq_filter_value(), .o_tx_acq_filter_override_en(ovr));
  // One APB transfer; answer taken at the edge that sees pready high
  task apb(input w, input [31:0] a, d);
    begin
      @(posedge i_core_clk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
      @(posedge i_core_clk) i_penable <= 1;
      @(posedge i_core_clk);
      while (o_pready !== 1'b1) @(posedge i_core_clk);
      err = o_pslverr;
      rd = o_prdata;
      {i_psel, i_penable} <= 2'h0;
    end
  endtask
  task chk(input [63:0] n, input [31:0] e, s);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  task rc(input [31:0] a, e);
    begin
      apb(0, a, 0);
      chk("read", e, rd);
    end
  endtask
  task t_reset;
    begin
      rc(32'h2e0, 32'hf5);
      rc(32'h334, 32'h8d);
      rc(32'h388, 32'h1e);
      chk("sel", 5, sw);
      chk("ovr", 0, ovr);
      $display("t_reset done");
    end
  endtask
  // Every swing code, with junk in the ignored middle bits
  task t_swing;
    for (k = 0; k < 8; k++) begin
      apb(1, 32'h2e0, 32'hc8 | k);
      @(posedge i_core_clk);
      @(negedge i_core_clk) chk("sel", k, sw);
      rc(32'h2e0, 32'hf0 | k);
    end
    $display("t_swing done");
  endtask
  task t_gain_filter;
    begin
      apb(1, 32'h334, 32'h0d);
      rc(32'h334, 32'h0d);
      chk("gain", 0, gn);
      lol <= 1;
      apb(1, 32'h388, 32'h98);
      rc(32'h388, 32'h98);
      lol <= 0;
      apb(1, 32'h388, 32'h00);
      rc(32'h388, 32'h1e);
      $display("t_gain_filter done");
    end
  endtask
  task t_float;
    begin
      @(posedge i_core_clk) {cnt, vld} <= {40'h5000000, 1'b1};
      @(posedge i_core_clk) vld <= 0;
      rc(32'h2d4, 32'h57);
      apb(1, 32'h2d4, 32'hff);
      rc(32'h2d4, 32'h57);
      apb(0, 32'h10, 0);
      chk("slverr", 1, err);
      $display("t_float done");
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Tests take well under 1000 cycles
  initial begin
    #20000 miscompares = miscompares + 1;
    report_and_stop;
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 0;
    t_reset;
    t_swing;
    t_gain_filter;
    t_float;
    report_and_stop;
  end
endmodule // tx_test_and_loop_ctl_regs_test
